// [pkg/wdc_map.vh]
`ifndef WDC_MAP_VH
`define WDC_MAP_VH
// Register byte offsets
`define WDC_OFF_CTL 8'hd8
`define WDC_OFF_XIEN 8'he8
`define WDC_OFF_IST 8'he0
`define WDC_OFF_IMASK 8'he4
`define WDC_OFF_UNL 8'hf4
// Control/status bit positions
`define WDC_B_BAUD2 7
`define WDC_B_POR 6
`define WDC_B_SPARE 5
`define WDC_B_TMOF 3
`define WDC_B_WRSTF 2
`define WDC_B_RSTEN 1
`define WDC_B_RESTART 0
// Extended enable layout
`define WDC_B_WIEN 4
`define WDC_XIEN_RSVD 3'b111
// Interrupt status bits
`define WDC_IS_TMO 0
`define WDC_IS_WRST 1
// Reset values
`define WDC_CTL_POR 8'h40
`define WDC_XIEN_RST 5'h00
// Bits forced low by any reset pattern
`define WDC_PAT_CLR 8'b1010_1001
// Unlock keys
`define WDC_KEY1 8'haa
`define WDC_KEY2 8'h55
// Timing
`define WDC_RST_DLY_CLKS 512
`define WDC_MC_CLKS 4
`define WDC_UNL_MCYC 3
`define WDC_TMO_CLKS 131072
`endif

// [hw/wdc_top.v]
`timescale 1ns/1ps
`include "wdc_map.vh"

// How it works
// - Top control bit drives baud doubling output
// - Power-on sets flag; only software clears
// - Timeout sets interrupt flag regardless of enable
// - Watchdog reset sets sticky reset flag
// - Power resets clear reset flag; external keeps
// - Reset enable low leaves reset flag alone
// - Watchdog reset only when enable set
// - Restart bit reloads count, clears itself
// - Interrupt at timeout, reset 512 clocks later
// - External reset clears bits 7,5,3,0 only
// - All readable; protected bits need unlock
// - AA then 55 opens three-cycle window
// - Upper three enable bits read as one
// - Enable bit 4 gates watchdog interrupt
// - Bits 3..0 gate external interrupts 5..2
module wdc_top #(
  parameter TIMEOUT_CLKS = `WDC_TMO_CLKS,
  parameter CNT_W = 18
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_reset_pin_n,
  input wire power_fail_pin,
  input wire power_down_pin,
  input wire [3:0] ext_irq_in,
  output reg second_serial_baud_double,
  output reg watchdog_reset_out,
  output reg watchdog_irq_req,
  output reg [3:0] ext_irq_req,
  output reg irq
);

  // Counts derived from the header, worked out at full width
  localparam [31:0] TMO_LAST_W = TIMEOUT_CLKS - 1;
  localparam [31:0] DLY_LAST_W = `WDC_RST_DLY_CLKS - 1;
  localparam [31:0] MC_LAST_W = `WDC_MC_CLKS - 1;
  localparam [31:0] UNL_MCYC_W = `WDC_UNL_MCYC;
  // Cut on purpose to the counter widths
  localparam [CNT_W-1:0] TMO_LAST = TMO_LAST_W[CNT_W-1:0];
  localparam [8:0] DLY_LAST = DLY_LAST_W[8:0];
  localparam [1:0] MC_LAST = MC_LAST_W[1:0];
  localparam [1:0] UNL_MCYC = UNL_MCYC_W[1:0];

  // Watchdog phases
  localparam PH_COUNT = 1'b0;
  localparam PH_DELAY = 1'b1;

  // Unlock sequencer states
  localparam UL_IDLE = 2'b00;
  localparam UL_HALF = 2'b01;
  localparam UL_OPEN = 2'b10;

  // Pin synchronisers, first and second stage
  reg [2:0] pin_s1_reg;
  reg [2:0] pin_s2_reg;

  // Register storage
  reg [7:0] wdctl_reg; // Watchdog control and status
  reg [4:0] xien_reg; // Extended interrupt enables
  reg [1:0] ist_reg; // Sticky interrupt status
  reg [1:0] imask_reg; // Interrupt mask

  // Watchdog engine
  reg [CNT_W-1:0] wd_cnt_reg;
  reg [8:0] dly_cnt_reg;
  reg phase_reg;

  // Timed access
  reg [1:0] unl_state_reg;
  reg [1:0] unl_left_reg; // Machine cycles left in window
  reg [1:0] mc_div_reg; // Machine cycle divider

  // Read data bits to clear at access edge
  reg [1:0] ist_rd_reg;

  // Decoded events
  wire ext_rst;
  wire pwr_rst;
  wire any_rst;
  wire mc_en;
  wire setup;
  wire acc;
  wire wr_en;
  wire hit_ctl;
  wire hit_xien;
  wire hit_ist;
  wire hit_imask;
  wire hit_unl;
  wire hit_any;
  wire unl_open;
  wire restart;
  wire tmo;
  wire fire;
  wire wd_rst;

  // Second stage only feeds logic
  assign ext_rst = ~pin_s2_reg[0];
  assign pwr_rst = pin_s2_reg[1] | pin_s2_reg[2];
  assign any_rst = ext_rst | pwr_rst;
  assign mc_en = (mc_div_reg == MC_LAST);

  // APB phases; pready marks the access cycle
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite;

  // Address decode
  assign hit_ctl = (paddr == `WDC_OFF_CTL);
  assign hit_xien = (paddr == `WDC_OFF_XIEN);
  assign hit_ist = (paddr == `WDC_OFF_IST);
  assign hit_imask = (paddr == `WDC_OFF_IMASK);
  assign hit_unl = (paddr == `WDC_OFF_UNL);
  assign hit_any = hit_ctl | hit_xien | hit_ist | hit_imask | hit_unl;

  // Protected writes only while window open
  assign unl_open = (unl_state_reg == UL_OPEN);

  // Restart request from a protected write of one
  assign restart = wr_en & hit_ctl & unl_open & pwdata[`WDC_B_RESTART];

  // Timeout at end of count phase
  assign tmo = (phase_reg == PH_COUNT) & (wd_cnt_reg == TMO_LAST) & ~restart;

  // Delay phase end, 512 clocks after timeout
  assign fire = (phase_reg == PH_DELAY) & (dly_cnt_reg == DLY_LAST) & ~restart;

  // Reset only when enabled
  assign wd_rst = fire & wdctl_reg[`WDC_B_RSTEN];

  // Two-flop pin synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 3'h1;
      pin_s2_reg <= 3'h1;
    end else begin
      pin_s1_reg <= {power_down_pin, power_fail_pin, ext_reset_pin_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Machine cycle enable divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_div_reg <= 2'h0;
    end else begin
      mc_div_reg <= mc_en ? 2'h0 : mc_div_reg + 2'h1;
    end
  end

  // Timed access sequencer
  // Any other write between the two keys, except a repeated AA, aborts the unlock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_state_reg <= UL_IDLE;
      unl_left_reg <= 2'h0;
    end else if (any_rst | wd_rst) begin
      unl_state_reg <= UL_IDLE;
      unl_left_reg <= 2'h0;
    end else if (wr_en & hit_unl) begin
      // Key writes
      if (pwdata[7:0] == `WDC_KEY1) begin
        unl_state_reg <= UL_HALF;
      end else if ((unl_state_reg == UL_HALF) & (pwdata[7:0] == `WDC_KEY2)) begin
        unl_state_reg <= UL_OPEN;
        unl_left_reg <= UNL_MCYC;
      end else begin
        unl_state_reg <= UL_IDLE;
      end
    end else if ((unl_state_reg == UL_HALF) & wr_en) begin
      // Second key must be the next write
      unl_state_reg <= UL_IDLE;
    end else if (unl_open & mc_en) begin
      // Count down machine cycles
      if (unl_left_reg == 2'h1) begin
        unl_state_reg <= UL_IDLE;
      end
      unl_left_reg <= unl_left_reg - 2'h1;
    end
  end

  // Watchdog counter and post-timeout delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_reg <= {CNT_W{1'b0}};
      dly_cnt_reg <= 9'h0;
      phase_reg <= PH_COUNT;
    end else if (any_rst | restart | fire) begin
      // Known starting state
      wd_cnt_reg <= {CNT_W{1'b0}};
      dly_cnt_reg <= 9'h0;
      phase_reg <= PH_COUNT;
    end else begin
      case (phase_reg)
        PH_COUNT: begin
          if (tmo) begin
            phase_reg <= PH_DELAY;
          end else begin
            wd_cnt_reg <= wd_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        PH_DELAY: begin
          dly_cnt_reg <= dly_cnt_reg + 9'h1;
        end
        default: begin
          phase_reg <= PH_COUNT;
        end
      endcase
    end
  end

  // Watchdog control and status register
  // Hardware sets win over software clears in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdctl_reg <= `WDC_CTL_POR;
    end else if (pwr_rst) begin
      // Pattern plus reset flag cleared
      wdctl_reg <= wdctl_reg & ~(`WDC_PAT_CLR | 8'h04);
    end else if (ext_rst) begin
      // Reset flag and enable kept
      wdctl_reg <= wdctl_reg & ~`WDC_PAT_CLR;
    end else if (wd_rst) begin
      // Chip reset by watchdog; cause recorded
      wdctl_reg <= (wdctl_reg & ~`WDC_PAT_CLR) | 8'h04;
    end else begin
      // Self-clearing restart bit
      wdctl_reg[`WDC_B_RESTART] <= 1'b0;
      if (wr_en & hit_ctl) begin
        // Unrestricted bits
        wdctl_reg[`WDC_B_BAUD2] <= pwdata[`WDC_B_BAUD2];
        wdctl_reg[`WDC_B_SPARE] <= pwdata[`WDC_B_SPARE];
        wdctl_reg[`WDC_B_WRSTF] <= pwdata[`WDC_B_WRSTF];
        if (unl_open) begin
          // Protected bits
          wdctl_reg[`WDC_B_POR] <= pwdata[`WDC_B_POR];
          wdctl_reg[`WDC_B_RSTEN] <= pwdata[`WDC_B_RSTEN];
          wdctl_reg[`WDC_B_TMOF] <= pwdata[`WDC_B_TMOF] | tmo;
          wdctl_reg[`WDC_B_RESTART] <= pwdata[`WDC_B_RESTART];
        end else if (tmo) begin
          wdctl_reg[`WDC_B_TMOF] <= 1'b1;
        end
      end else if (tmo) begin
        // Set regardless of interrupt enable
        wdctl_reg[`WDC_B_TMOF] <= 1'b1;
      end
    end
  end

  // Extended interrupt enable register
  // Enables drop on every reset kind
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xien_reg <= `WDC_XIEN_RST;
    end else if (any_rst | wd_rst) begin
      xien_reg <= `WDC_XIEN_RST;
    end else if (wr_en & hit_xien) begin
      xien_reg <= pwdata[4:0];
    end
  end

  // Interrupt mask register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_reg <= 2'h0;
    end else if (wr_en & hit_imask) begin
      imask_reg <= pwdata[1:0];
    end
  end

  // Sticky status; read clears only what was returned
  // so an event landing during the read is kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= 2'h0;
    end else begin
      ist_reg[`WDC_IS_TMO] <= tmo | (ist_reg[`WDC_IS_TMO] & ~ist_rd_reg[`WDC_IS_TMO]);
      ist_reg[`WDC_IS_WRST] <= wd_rst | (ist_reg[`WDC_IS_WRST] & ~ist_rd_reg[`WDC_IS_WRST]);
    end
  end

  // APB answer: data captured in setup, ready in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ist_rd_reg <= 2'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_any;
      ist_rd_reg <= 2'h0;
      if (setup & ~pwrite) begin
        // Read mux
        if (hit_ctl) begin
          prdata <= {24'h00_0000, wdctl_reg & 8'hef};
        end else if (hit_xien) begin
          prdata <= {24'h00_0000, `WDC_XIEN_RSVD, xien_reg};
        end else if (hit_ist) begin
          prdata <= {30'h0000_0000, ist_reg};
          ist_rd_reg <= ist_reg;
        end else if (hit_imask) begin
          prdata <= {30'h0000_0000, imask_reg};
        end else if (hit_unl) begin
          // Unlock state visible for debug
          prdata <= {30'h0000_0000, unl_state_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else if (acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Registered outputs toward serial, reset and interrupt logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_serial_baud_double <= 1'b0;
      watchdog_reset_out <= 1'b0;
      watchdog_irq_req <= 1'b0;
      ext_irq_req <= 4'h0;
      irq <= 1'b0;
    end else begin
      second_serial_baud_double <= wdctl_reg[`WDC_B_BAUD2];
      watchdog_reset_out <= wd_rst;
      // Flag gated by its enable
      watchdog_irq_req <= wdctl_reg[`WDC_B_TMOF] & xien_reg[`WDC_B_WIEN];
      // Bit 3 is irq5 down to bit 0 irq2
      ext_irq_req <= ext_irq_in & xien_reg[3:0];
      irq <= |(ist_reg & imask_reg);
    end
  end

endmodule // wdc_top

// [testbench/wdc_top_sva.sv]
`timescale 1ns/1ps
// Port-level checker for the watchdog control block
module wdc_top_sva(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [3:0] ext_irq_in,
  input wire [3:0] ext_irq_req,
  input wire watchdog_reset_out
);
  // Single clock domain, so one clocking and one disable
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_xien_rsvd: assert property (pready && !pwrite && paddr == 8'he8 |-> prdata[7:5] == 3'h7)
    else $error("reserved enable bits not high");
  a_ext_gate: assert property ((ext_irq_req & ~$past(ext_irq_in)) == 4'h0)
    else $error("request without input");
  a_rst_pulse: assert property (watchdog_reset_out |=> !watchdog_reset_out)
    else $error("reset pulse too long");
  a_ctl_mapped: assert property (pready && paddr == 8'hd8 |-> !pslverr)
    else $error("control access refused");
endmodule // wdc_top_sva

bind wdc_top wdc_top_sva u_sva(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_irq_in(ext_irq_in), .ext_irq_req(ext_irq_req), .watchdog_reset_out(watchdog_reset_out));

// [testbench/wdc_far.sv]
`timescale 1ns/1ps
// Reset source model: external, power-fail and power-down request pins
module wdc_far(
  input wire pclk,
  output logic ext_reset_pin_n,
  output logic power_fail_pin,
  output logic power_down_pin
);
  // Idle: no reset requested
  initial begin
    ext_reset_pin_n = 1'b1;
    power_fail_pin = 1'b0;
    power_down_pin = 1'b0;
  end
  // Kind 0 external, 1 power fail, 2 power down; held 4 clocks, then
  // 4 more so the synchroniser has settled before software looks
  task hit(input int k);
    ext_reset_pin_n <= (k != 0);
    power_fail_pin <= (k == 1);
    power_down_pin <= (k == 2);
    repeat (4) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
    power_fail_pin <= 1'b0;
    power_down_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // wdc_far

// [testbench/tb_watchdog_control_flags.sv]
`timescale 1ns/1ps
module tb_watchdog_control_flags;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] ext_irq_in = 4'h0;
  logic [3:0] en;
  wire [31:0] prdata;
  wire pready, pslverr, ext_n, pfail, pdown, baud, wrst, wirq, irq;
  wire [3:0] ext_irq_req;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  always #5 pclk = ~pclk;
  // Short timeout keeps the run brief, yet outlasts the opening register tests
  wdc_top #(.TIMEOUT_CLKS(96)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_pin_n(ext_n), .power_fail_pin(pfail), .power_down_pin(pdown), .ext_irq_in(ext_irq_in),
    .second_serial_baud_double(baud), .watchdog_reset_out(wrst), .watchdog_irq_req(wirq),
    .ext_irq_req(ext_irq_req), .irq(irq));
  wdc_far u_far(.pclk(pclk), .ext_reset_pin_n(ext_n), .power_fail_pin(pfail), .power_down_pin(pdown));
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; holds everything until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    // One idle edge so the next call never re-drives these in the same step
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    apb(0, a, 8'h00);
  endtask
  task unlock;
    apb(1, 8'hf4, 8'haa);
    apb(1, 8'hf4, 8'h55);
  endtask
  // Monitor: error flag on every access, read data against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      check(pslverr, !(paddr inside {8'hd8, 8'he8, 8'he0, 8'he4, 8'hf4}), "slverr");
      if (!pwrite) check(prdata, exp_q.pop_front(), "rdata");
    end
  end
  task complete_run;
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
  initial begin
    n = $urandom(32'h6e05);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(8'hd8, 8'h40);
    rd(8'he8, 8'he0);
    rd(8'h10, 8'h00);
    apb(1, 8'hd8, 8'hff); // Locked: only bits 7,5,2 land
    rd(8'hd8, 8'he4);
    check(baud, 1, "baud");
    unlock();
    apb(1, 8'hd8, 8'h02);
    rd(8'hd8, 8'h02);
    check(baud, 0, "baud");
    repeat (14) @(posedge pclk);
    apb(1, 8'hd8, 8'h00); // Window has closed
    rd(8'hd8, 8'h02);
    en = 4'($urandom);
    ext_irq_in <= 4'($urandom);
    apb(1, 8'he8, {4'h1, en});
    apb(1, 8'he4, 8'h03);
    unlock();
    apb(1, 8'hd8, 8'h03);
    check(ext_irq_req, ext_irq_in & en, "ext_req");
    n = 0;
    while (wirq !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check(wirq, 1, "wirq");
    check(irq, 1, "irq");
    n = 0;
    while (wrst !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    check(n >= 509 && n <= 513, 1, "reset_delay");
    @(posedge pclk);
    rd(8'hd8, 8'h06);
    rd(8'he0, 8'h03);
    rd(8'he0, 8'h00); // Read cleared the status
    check(irq, 0, "irq");
    u_far.hit(0);
    rd(8'hd8, 8'h06);
    rd(8'he8, 8'he0);
    u_far.hit(1);
    rd(8'hd8, 8'h02);
    u_far.hit(2);
    rd(8'hd8, 8'h02);
    apb(1, 8'he4, 8'h00); // Mask everything
    for (int i = 0; i < 3; i++) begin
      repeat (40) @(posedge pclk);
      unlock();
      apb(1, 8'hd8, 8'h01);
    end
    rd(8'hd8, 8'h00);
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      n += wrst;
    end
    check(n, 0, "no_reset");
    check(irq, 0, "irq_masked");
    rd(8'hd8, 8'h08);
    complete_run();
  end
endmodule // tb_watchdog_control_flags
